// [core/trbcs_regs.vh]
// constants for the tape read bit and character sync block
// assumes a 100 MHz controller clock and one tape track at a time
`ifndef TRBCS_REGS_VH
`define TRBCS_REGS_VH

// timing: one bit cell at 1000 bpi and 5 ips, in ns
`define TRBCS_CELL_NS     200000
`define TRBCS_CLK_NS      10

// timing windows, in quarters of a bit cell
`define TRBCS_Q_PER_CELL  4
`define TRBCS_Q_DATA_LO   3
`define TRBCS_Q_DATA_HI   5
`define TRBCS_Q_PAR_LO    7
`define TRBCS_Q_END       10

// widths and depths
`define TRBCS_CNT_W       16
`define TRBCS_DATA_W      8
`define TRBCS_FIFO_D      16
`define TRBCS_FIFO_AW     4
`define TRBCS_BCNT_W      4
`define TRBCS_BITS_CHAR   4'h8

// read sequencer states
`define TRBCS_ST_IDLE     2'h0
`define TRBCS_ST_WAIT     2'h1
`define TRBCS_ST_TRACK    2'h2
`define TRBCS_ST_LOST     2'h3

`endif

// [core/trbcs_sync.v]
// three-stage input synchroniser for the head read signal
// assumes an asynchronous level input; output is a clean level on clk_i
module trbcs_sync (
	input  wire clk_i,
	input  wire reset_i,
	input  wire async_i,
	output wire level_o
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg level_r;

	// s1 feeds only s2; a change counts once s2 and s3 agree
	always @(posedge clk_i) begin
		if (reset_i) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_r <= 1'b0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r; // filters a single-cycle glitch
			end
		end
	end

	assign level_o = level_r;
endmodule

// [core/trbcs_fifo.v]
// character buffer between the decoder and the controller side
// assumes one clock, synchronous flush; first word shows without a pop
module trbcs_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clk_i,
	input  wire          reset_i,
	input  wire          in_valid_i,
	output wire          in_ready_o,
	input  wire [W-1:0]  in_data_i,
	output wire          out_valid_o,
	input  wire          out_ready_i,
	output wire [W-1:0]  out_data_o
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0]   count_r;
	wire         push;
	wire         pop;

	// full and empty come straight from the occupancy count
	assign in_ready_o  = (count_r != D[AW:0]);
	assign out_valid_o = (count_r != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// storage has no reset; only pointers and count are cleared
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_r] <= in_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			wr_r    <= {AW{1'b0}};
			rd_r    <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_r <= wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= rd_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule

// [core/trbcs_top.v]
// read-side bit and character synchroniser for a phase-encoded tape track
// assumes rd_flux_i is the raw head signal and rd_cmd_i a same-clock pulse
// characters leave through a 16-word buffer at the consumer's pace

`include "trbcs_regs.vh"

// Behaviour
// - after a read command, first transition sets bit timing for the read
// - lost bit timing returns at next differing bit pair or character end
// - each data bit is read from its mid-cell transition direction
// - parity spans two cells, silent first cell, transition mid second cell
// - every ninth bit is checked; parity pattern confirms character alignment
// - ninth bit not parity: search bit by bit, realign on next parity
// - data loss limited to the bad character, which realigns on its own parity
// - any loss of character alignment raises the character error pulse
// - a character is eight data bits then one double-width parity bit
// - no start transition between characters, only before the first
module trbcs_top #(
	parameter CELL_CYC = `TRBCS_CELL_NS / `TRBCS_CLK_NS
) (
	input  wire                     clk_i,
	input  wire                     reset_i,
	input  wire                     rd_cmd_i,
	input  wire                     rd_flux_i,
	input  wire                     char_ready_i,
	output wire [`TRBCS_DATA_W-1:0] char_data_o,
	output wire                     char_valid_o,
	output wire                     char_err_o,
	output wire                     overrun_o,
	output wire                     busy_o,
	output wire                     bit_sync_o,
	output wire                     char_sync_o
);
	// data edges land near 4Q after the last mid edge, parity near 8Q;
	// gaps between 5Q and 7Q belong to neither, so they mean slipped timing
	// limitation: 16-bit gap counter, so CELL_CYC above 26215 would wrap
	// window limits in clock cycles, from quarter-cell steps
	localparam integer QC      = CELL_CYC / `TRBCS_Q_PER_CELL;
	localparam [31:0]  DATA_LO = QC * `TRBCS_Q_DATA_LO;
	localparam [31:0]  DATA_HI = QC * `TRBCS_Q_DATA_HI;
	localparam [31:0]  PAR_LO  = QC * `TRBCS_Q_PAR_LO;
	localparam [31:0]  END_LIM = QC * `TRBCS_Q_END;

	reg  [1:0]                 state_r;
	reg  [`TRBCS_CNT_W-1:0]    cnt_r;
	reg  [`TRBCS_BCNT_W-1:0]   bitcnt_r;
	reg  [`TRBCS_DATA_W-1:0]   shift_r;
	reg                        hunt_r;
	reg                        flux_prev_r;
	reg                        push_r;
	reg  [`TRBCS_DATA_W-1:0]   push_data_r;
	reg                        char_err_r;
	reg                        overrun_r;
	reg                        busy_r;
	reg                        bit_sync_r;
	reg                        char_sync_r;
	reg  [`TRBCS_DATA_W-1:0]   char_data_r;
	reg                        char_valid_r;
	wire                       flux_lvl;
	wire                       edge_seen;
	wire [31:0]                gap;
	wire                       fifo_in_ready;
	wire                       fifo_out_valid;
	wire [`TRBCS_DATA_W-1:0]   fifo_out_data;
	wire                       pop;
	wire                       flush;
	wire                       busy_nxt;
	wire                       bit_sync_nxt;
	wire                       char_sync_nxt;
	reg                        cls_early;
	reg                        cls_data;
	reg                        cls_par;
	reg                        cls_end;

	// true when a gap count lies at or above a limit
	function at_least;
		input [31:0] g;
		input [31:0] lim;
		begin
			at_least = (g >= lim);
		end
	endfunction

	// true when a gap count lies inside an inclusive window
	function in_win;
		input [31:0] g;
		input [31:0] lo;
		input [31:0] hi;
		begin
			in_win = (g >= lo) && (g <= hi);
		end
	endfunction

	// four flops on the head signal; their latency cancels in every gap
	trbcs_sync u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i (rd_flux_i),
		.level_o (flux_lvl)
	);

	// a read command starts a fresh record, so stale characters go
	assign flush = reset_i || rd_cmd_i;

	trbcs_fifo #(
		.W  (`TRBCS_DATA_W),
		.D  (`TRBCS_FIFO_D),
		.AW (`TRBCS_FIFO_AW)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (flush),
		.in_valid_i  (push_r),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (push_data_r),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out_data)
	);

	// any flux change is a candidate transition
	assign edge_seen = (flux_lvl != flux_prev_r);
	assign gap       = {16'h0000, cnt_r};

	// edge class from the gap since the last counted edge; tracking and
	// recovery share it so both judge an edge by the same windows
	always @* begin
		cls_early = 1'b0;
		cls_data  = 1'b0;
		cls_par   = 1'b0;
		cls_end   = at_least(gap, END_LIM);
		if (at_least(gap, PAR_LO)) begin
			cls_par = 1'b1;
		end else if (in_win(gap, DATA_LO, DATA_HI)) begin
			cls_data = 1'b1;
		end else if (!at_least(gap, DATA_LO)) begin
			cls_early = 1'b1;
		end
	end

	// one strobe every other cycle at most, gated by the consumer
	assign pop = fifo_out_valid && char_ready_i && !char_valid_r;

	// a data bit: shifted in, or used only as a search step
	task take_data;
		begin
			if (hunt_r) begin
				bitcnt_r <= bitcnt_r;
			end else if (bitcnt_r == `TRBCS_BITS_CHAR) begin
				hunt_r     <= 1'b1;
				char_err_r <= 1'b1;
			end else begin
				shift_r  <= {flux_lvl, shift_r[`TRBCS_DATA_W-1:1]};
				bitcnt_r <= bitcnt_r + 1'b1;
			end
		end
	endtask

	// a parity bit: confirms alignment or realigns on itself
	task take_parity;
		begin
			if (!hunt_r && bitcnt_r == `TRBCS_BITS_CHAR) begin
				// buffer full means this character is lost, flagged as overrun
				if (fifo_in_ready) begin
					push_r      <= 1'b1;
					push_data_r <= shift_r;
				end else begin
					overrun_r <= 1'b1;
				end
			end else if (!hunt_r) begin
				char_err_r <= 1'b1;
			end
			// parity value is not checked, only its place in the stream
			hunt_r   <= 1'b0;
			bitcnt_r <= {`TRBCS_BCNT_W{1'b0}};
		end
	endtask

	// read sequencer: start search, tracking, and lost-timing recovery
	always @(posedge clk_i) begin
		if (reset_i) begin
			state_r     <= `TRBCS_ST_IDLE;
			cnt_r       <= {`TRBCS_CNT_W{1'b0}};
			bitcnt_r    <= {`TRBCS_BCNT_W{1'b0}};
			shift_r     <= {`TRBCS_DATA_W{1'b0}};
			hunt_r      <= 1'b0;
			flux_prev_r <= 1'b0;
			push_r      <= 1'b0;
			push_data_r <= {`TRBCS_DATA_W{1'b0}};
			char_err_r  <= 1'b0;
			overrun_r   <= 1'b0;
		end else begin
			flux_prev_r <= flux_lvl;
			push_r      <= 1'b0;
			char_err_r  <= 1'b0;
			// a new read drops any half-built character and its alignment
			if (rd_cmd_i) begin
				state_r  <= `TRBCS_ST_WAIT;
				cnt_r    <= {`TRBCS_CNT_W{1'b0}};
				bitcnt_r <= {`TRBCS_BCNT_W{1'b0}};
				hunt_r   <= 1'b0;
				overrun_r <= 1'b0;
			end else begin
				case (state_r)
				`TRBCS_ST_IDLE: begin
					cnt_r <= {`TRBCS_CNT_W{1'b0}};
				end
				`TRBCS_ST_WAIT: begin
					// start transition fixes the phase of the first cell
					// it carries no data; the first mid edge follows a cell later
					if (edge_seen) begin
						state_r  <= `TRBCS_ST_TRACK;
						cnt_r    <= {`TRBCS_CNT_W{1'b0}};
						bitcnt_r <= {`TRBCS_BCNT_W{1'b0}};
					end
				end
				`TRBCS_ST_TRACK: begin
					// early edges are cell boundaries and carry no data
					if (edge_seen && !cls_early) begin
						cnt_r <= {`TRBCS_CNT_W{1'b0}};
						if (cls_data) begin
							take_data;
						end else if (cls_par) begin
							take_parity;
						end else begin
							// edge between windows: timing has slipped
							state_r <= `TRBCS_ST_LOST;
							hunt_r  <= 1'b1;
							if (!hunt_r) begin
								char_err_r <= 1'b1;
							end
						end
					end else if (cls_end) begin
						// long silence is the end of the record
						state_r <= `TRBCS_ST_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				`TRBCS_ST_LOST: begin
					// a lone edge after a long gap must be mid-cell
					// boundary edges restart the count here, so only a differing
					// bit pair or the parity gap can end the search
					if (edge_seen) begin
						cnt_r <= {`TRBCS_CNT_W{1'b0}};
						if (cls_par) begin
							state_r <= `TRBCS_ST_TRACK;
							take_parity;
						end else if (!cls_early) begin
							state_r <= `TRBCS_ST_TRACK;
						end
					end else if (cls_end) begin
						state_r <= `TRBCS_ST_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= `TRBCS_ST_IDLE;
				end
				endcase
			end
		end
	end

	// next status values; a fresh error hides char sync for a cycle
	assign busy_nxt      = (state_r != `TRBCS_ST_IDLE);
	assign bit_sync_nxt  = (state_r == `TRBCS_ST_TRACK);
	assign char_sync_nxt = bit_sync_nxt && !hunt_r && !char_err_r;

	// status outputs lag the sequencer by one cycle to stay registered
	always @(posedge clk_i) begin
		if (reset_i) begin
			busy_r      <= 1'b0;
			bit_sync_r  <= 1'b0;
			char_sync_r <= 1'b0;
		end else begin
			busy_r      <= busy_nxt;
			bit_sync_r  <= bit_sync_nxt;
			char_sync_r <= char_sync_nxt;
		end
	end

	// character hand-over: data and strobe both from flops
	// data holds between strobes so a slow consumer may read it late
	always @(posedge clk_i) begin
		if (reset_i) begin
			char_data_r  <= {`TRBCS_DATA_W{1'b0}};
			char_valid_r <= 1'b0;
		end else begin
			char_valid_r <= pop;
			if (pop) begin
				char_data_r <= fifo_out_data;
			end
		end
	end

	assign char_data_o  = char_data_r;
	assign char_valid_o = char_valid_r;
	assign char_err_o   = char_err_r;
	assign overrun_o    = overrun_r;
	assign busy_o       = busy_r;
	assign bit_sync_o   = bit_sync_r;
	assign char_sync_o  = char_sync_r;
endmodule

// [sim/trbcs_tape_model.sv]
// tape read channel model: writes phase-encoded records onto the flux line
// assumes clk_i is the controller clock; cell length given in clocks
module trbcs_tape_model #(
	parameter int CELL = 40
) (
	input  wire logic clk_i,
	output logic      flux_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// erased tape holds one level, no edges between records
	initial flux_o = 1'b0;
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// start edge one cell ahead of the first mid-cell edge
	task automatic start_rec();
		flux_o <= ~flux_o;
		hold(CELL / 2);
	endtask
	// nb data cells lsb first, rising mid edge is a one
	// skew delays the first mid edge, which slips the bit timing
	task automatic send_char(input logic [8:0] d, input int nb, input int skew);
		for (int i = 0; i < nb; i++) begin
			flux_o <= ~d[i];
			hold(CELL / 2 + ((i == 0) ? skew : 0));
			flux_o <= d[i];
			hold(CELL / 2);
		end
		// parity: silent first cell, edge mid second cell
		hold(CELL + CELL / 2);
		flux_o <= ~flux_o;
		hold(CELL / 2);
	endtask
endmodule

// [sim/trbcs_props.sv]
// port checker for the tape bit and character synchroniser
// assumes it is bound to trbcs_top and sees only its ports
`include "trbcs_regs.vh"
module trbcs_props #(
	parameter CELL_CYC = 40
) (
	input wire                     clk_i,
	input wire                     reset_i,
	input wire                     rd_cmd_i,
	input wire                     char_ready_i,
	input wire [`TRBCS_DATA_W-1:0] char_data_o,
	input wire                     char_valid_o,
	input wire                     char_err_o,
	input wire                     overrun_o,
	input wire                     busy_o,
	input wire                     bit_sync_o,
	input wire                     char_sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_valid_pulse; char_valid_o |=> !char_valid_o; endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
	property p_err_pulse; char_err_o |=> !char_err_o; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error longer than one cycle");
	property p_sync_nest; char_sync_o |-> bit_sync_o; endproperty
	a_sync_nest: assert property (p_sync_nest) else $error("char sync without bit sync");
	property p_cmd_restart; rd_cmd_i |-> ##2 (!bit_sync_o && !char_sync_o); endproperty
	a_cmd_restart: assert property (p_cmd_restart) else $error("sync kept over command");
	property p_err_drops; char_err_o |=> !char_sync_o; endproperty
	a_err_drops: assert property (p_err_drops) else $error("char sync kept after error");
	property p_ovr_sticky; overrun_o && !rd_cmd_i |=> overrun_o; endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun cleared early");
	property p_data_hold; !char_valid_o |-> $stable(char_data_o); endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved without strobe");
	property p_idle_nosync; !busy_o |-> !bit_sync_o; endproperty
	a_idle_nosync: assert property (p_idle_nosync) else $error("bit sync while idle");
	property p_ready_pop; char_valid_o |-> $past(char_ready_i); endproperty
	a_ready_pop: assert property (p_ready_pop) else $error("strobe without ready");
endmodule
bind trbcs_top trbcs_props #(.CELL_CYC(CELL_CYC)) u_props (.clk_i(clk_i), .reset_i(reset_i),
	.rd_cmd_i(rd_cmd_i), .char_ready_i(char_ready_i), .char_data_o(char_data_o),
	.char_valid_o(char_valid_o), .char_err_o(char_err_o), .overrun_o(overrun_o),
	.busy_o(busy_o), .bit_sync_o(bit_sync_o), .char_sync_o(char_sync_o));

// [sim/tb.sv]
// self-checking bench for the tape bit and character synchroniser
// assumes a 100 MHz clock and a shortened 40-clock bit cell
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CELL = 40;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       rd_cmd_i = 1'b0;
	logic       char_ready_i = 1'b1;
	logic       rd_flux_i;
	logic       rdy_rand = 1'b0;
	logic       rdy_lvl = 1'b1;
	logic [7:0] char_data_o;
	logic       char_valid_o, char_err_o, overrun_o, busy_o, bit_sync_o, char_sync_o;
	logic [7:0] exp_q[$];
	int         num_errors = 0;
	int         checked = 0;
	int         n_err_seen = 0;
	int         cyc = 0;
	trbcs_top #(.CELL_CYC(CELL)) uut (.clk_i(clk_i), .reset_i(reset_i), .rd_cmd_i(rd_cmd_i),
		.rd_flux_i(rd_flux_i), .char_ready_i(char_ready_i), .char_data_o(char_data_o),
		.char_valid_o(char_valid_o), .char_err_o(char_err_o), .overrun_o(overrun_o),
		.busy_o(busy_o), .bit_sync_o(bit_sync_o), .char_sync_o(char_sync_o));
	trbcs_tape_model #(.CELL(CELL)) u_tape (.clk_i(clk_i), .flux_o(rd_flux_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t byte got %h exp %h", $time, g, e);
		end
	endtask
	task automatic check_bit(input logic g, input logic e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t flag got %b exp %b", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checked=%0d num_errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// strobed characters are compared in the order they went on tape
	always @(posedge clk_i) begin
		if (char_valid_o === 1'b1) begin
			if (exp_q.size() == 0) check_bit(1'b1, 1'b0);
			else check_byte(char_data_o, exp_q.pop_front());
		end
		if (char_err_o === 1'b1) n_err_seen++;
		char_ready_i <= rdy_rand ? 1'($urandom_range(1, 0)) : rdy_lvl;
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end
	// expected byte for slot k: corner values first, then random ones
	function automatic logic [7:0] pick_byte(input int k);
		return (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? 8'h5a : 8'($urandom);
	endfunction
	// bad index gets a ninth data cell, or with skew a late first mid edge
	task automatic record(input int n, input int bad, input int keep, input int skew);
		logic [7:0] d;
		@(posedge clk_i) rd_cmd_i <= 1'b1;
		@(posedge clk_i) rd_cmd_i <= 1'b0;
		u_tape.hold(4);
		check_bit(busy_o, 1'b1);
		u_tape.start_rec();
		for (int k = 0; k < n; k++) begin
			d = pick_byte(k);
			if (k != bad && exp_q.size() < keep) exp_q.push_back(d);
			u_tape.send_char({1'b0, d}, (k == bad && skew == 0) ? 9 : 8,
				(k == bad) ? skew : 0);
		end
		check_bit(bit_sync_o, 1'b1);
		check_bit(char_sync_o, 1'b1);
	endtask
	task automatic settle();
		int n;
		n = 0;
		while ((busy_o !== 1'b0 || exp_q.size() != 0) && n < 600) begin
			@(posedge clk_i);
			n++;
		end
		check_bit(busy_o, 1'b0);
	endtask
	initial begin
		void'($urandom(1));
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		// clean record, consumer ready at random
		rdy_rand <= 1'b1;
		record(7, -1, 99, 0);
		rdy_rand <= 1'b0;
		settle();
		check_byte(8'(exp_q.size()), 8'h00);
		check_byte(8'(n_err_seen), 8'h00);
		// ninth cell is data: one error, only that character lost
		record(6, 3, 99, 0);
		settle();
		check_byte(8'(n_err_seen), 8'h01);
		// late first edge slips bit timing: one error, only that character lost
		record(6, 2, 99, CELL * 3 / 8);
		settle();
		check_byte(8'(n_err_seen), 8'h02);
		// stalled consumer: buffer fills to 16 and later characters drop
		@(posedge clk_i) rdy_lvl <= 1'b0;
		record(18, -1, 16, 0);
		u_tape.hold(120);
		check_bit(overrun_o, 1'b1);
		rdy_lvl <= 1'b1;
		settle();
		check_byte(8'(exp_q.size()), 8'h00);
		print_verdict();
	end
endmodule
